// ---- logic/pcx_port_crossbar.sv ----
// Lower-port crossbar, port configuration and edge interrupt logic.
// Assumes one hclk domain; pins arrive asynchronously and are synced.
`timescale 1ns/1ps
`default_nettype none

module pcx_port_crossbar (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pullup_en,
  input  wire logic        serial_a_transmit,
  output logic             serial_a_receive,
  input  wire logic        sda_drive,
  output logic             sda_in,
  input  wire logic        scl_drive,
  output logic             scl_in,
  input  wire logic        serial_b_transmit,
  output logic             serial_b_receive,
  output logic             ext_irq_input_a,
  output logic             ext_irq_input_b,
  input  wire logic        memif_muxed,
  input  wire logic        memif_active,
  input  wire logic        memif_read,
  input  wire logic [31:0] memif_pin_mask,
  input  wire logic [31:0] memif_data_mask,
  input  wire logic [31:0] memif_out,
  output logic             edge_irq_a_req,
  output logic             edge_irq_b_req
);

  localparam int NSIG = pcx_pkg::NSIG;

  logic [7:0]  port_data [4];
  logic [7:0]  port_output_mode_reg [4];
  logic [7:0]  port1_input_mode_reg;
  logic [7:0]  crossbar_cfg_a;
  logic [7:0]  crossbar_cfg_b;
  logic [7:0]  crossbar_cfg_c;
  logic [7:0]  port3_irq_flag_reg;
  logic [1:0]  irq_enable;
  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic [1:0]  edge_prev;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic [31:0] next_rdata;
  logic [31:0] analog;
  logic [31:0] skip;
  logic [31:0] pin_read;
  logic [NSIG-1:0] sig_en;
  logic [NSIG-1:0] sig_hit;
  logic [NSIG-1:0] sig_out;
  logic [4:0]  sig_pin [NSIG];
  logic [31:0] gp_val;
  logic [31:0] pp;
  logic [31:0] drv_val;
  logic [31:0] drv_en;
  logic [1:0]  edge_seen;
  logic        acc_ok;
  logic        edge_wr;

  // Register index from byte address
  function automatic logic [1:0] port_idx(input logic [7:0] a);
    port_idx = a[3:2];
  endfunction : port_idx

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
  endfunction : in_range

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc_ok    = hsel && hready &&
                     (htrans == pcx_pkg::HTRANS_NONSEQ ||
                      htrans == pcx_pkg::HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_write <= acc_ok && hwrite;
      dp_addr  <= haddr;
    end
  end

  // Two-flop pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 32'h0000_0000;
      pin_sync <= 32'h0000_0000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Analog and skip maps
  always_comb begin
    analog = 32'h0000_0000;
    analog[pcx_pkg::PIN_P1_BASE +: 8] = ~port1_input_mode_reg;
    skip = analog;
    if (crossbar_cfg_c[pcx_pkg::XC_MEMIF_LOW]) begin
      skip[pcx_pkg::PIN_MEMIF_RD] = 1'b1;
      skip[pcx_pkg::PIN_MEMIF_WR] = 1'b1;
      skip[pcx_pkg::PIN_MEMIF_ALE] = memif_muxed;
    end
    pin_read = pin_sync & ~analog;
  end

  // Enabled crossbar signals in priority order
  always_comb begin
    sig_en = '0;
    sig_en[pcx_pkg::SIG_SERA_TX] = crossbar_cfg_a[pcx_pkg::XA_SERA_EN];
    sig_en[pcx_pkg::SIG_SERA_RX] = crossbar_cfg_a[pcx_pkg::XA_SERA_EN];
    sig_en[pcx_pkg::SIG_SDA]     = crossbar_cfg_a[pcx_pkg::XA_SMBUS_EN];
    sig_en[pcx_pkg::SIG_SCL]     = crossbar_cfg_a[pcx_pkg::XA_SMBUS_EN];
    sig_en[pcx_pkg::SIG_SERB_TX] = crossbar_cfg_c[pcx_pkg::XC_SERB_EN];
    sig_en[pcx_pkg::SIG_SERB_RX] = crossbar_cfg_c[pcx_pkg::XC_SERB_EN];
    sig_en[pcx_pkg::SIG_IRQA]    = crossbar_cfg_b[pcx_pkg::XB_IRQA_EN];
    sig_en[pcx_pkg::SIG_IRQB]    = crossbar_cfg_b[pcx_pkg::XB_IRQB_EN];
    sig_out = '1;
    sig_out[pcx_pkg::SIG_SERA_TX] = serial_a_transmit;
    sig_out[pcx_pkg::SIG_SDA]     = sda_drive;
    sig_out[pcx_pkg::SIG_SCL]     = scl_drive;
    sig_out[pcx_pkg::SIG_SERB_TX] = serial_b_transmit;
  end

  // Allocation: k-th enabled signal to k-th unskipped pin
  always_comb begin
    logic [5:0] srank;
    logic [5:0] prank;
    srank = 6'h00;
    prank = 6'h00;
    sig_hit = '0;
    for (int s = 0; s < NSIG; s++) begin
      sig_pin[s] = 5'h00;
    end
    for (int s = 0; s < NSIG; s++) begin
      if (sig_en[s]) begin
        prank = 6'h00;
        for (int p = 0; p < 32; p++) begin
          if (!skip[p]) begin
            if (prank == srank && !sig_hit[s]) begin
              sig_hit[s] = 1'b1;
              sig_pin[s] = 5'(p);
            end
            prank = prank + 6'h01;
          end
        end
        srank = srank + 6'h01;
      end
    end
  end

  // Pin output drive
  always_comb begin
    for (int p = 0; p < 32; p++) begin
      gp_val[p] = port_data[p / 8][p % 8];
      pp[p]     = port_output_mode_reg[p / 8][p % 8];
    end
    drv_val = gp_val;
    drv_en  = pp | ~gp_val;
    for (int s = 0; s < NSIG; s++) begin
      if (sig_hit[s]) begin
        drv_val[sig_pin[s]] = sig_out[s];
        if (pcx_pkg::SIG_IS_INPUT[s]) begin
          drv_en[sig_pin[s]] = 1'b0;
        end else if (pcx_pkg::SIG_IS_OD[s]) begin
          drv_en[sig_pin[s]] = ~sig_out[s];
        end else begin
          drv_en[sig_pin[s]] = pp[sig_pin[s]] | ~sig_out[s];
        end
      end
    end
    if (crossbar_cfg_c[pcx_pkg::XC_MEMIF_LOW] && memif_active) begin
      for (int p = 0; p < 32; p++) begin
        if (memif_pin_mask[p]) begin
          drv_val[p] = memif_out[p];
          drv_en[p]  = pp[p] | ~memif_out[p];
        end
        if (memif_read && memif_data_mask[p]) begin
          drv_en[p] = 1'b0;
        end
      end
    end
    if (!crossbar_cfg_c[pcx_pkg::XC_XBAR_EN]) begin
      drv_en = 32'h0000_0000;
    end
  end

  assign pin_out = drv_val;
  assign pin_oe  = drv_en;
  assign pin_pullup_en = {32{~crossbar_cfg_c[pcx_pkg::XC_PU_DIS]}}
                         & ~(drv_en & ~drv_val)
                         & ~analog;

  // Peripheral inputs from assigned pins; idle high otherwise
  always_comb begin
    serial_a_receive = 1'b1;
    sda_in           = 1'b1;
    scl_in           = 1'b1;
    serial_b_receive = 1'b1;
    ext_irq_input_a  = 1'b1;
    ext_irq_input_b  = 1'b1;
    if (sig_hit[pcx_pkg::SIG_SERA_RX]) begin
      serial_a_receive = pin_read[sig_pin[pcx_pkg::SIG_SERA_RX]];
    end
    if (sig_hit[pcx_pkg::SIG_SDA]) begin
      sda_in = pin_read[sig_pin[pcx_pkg::SIG_SDA]];
    end
    if (sig_hit[pcx_pkg::SIG_SCL]) begin
      scl_in = pin_read[sig_pin[pcx_pkg::SIG_SCL]];
    end
    if (sig_hit[pcx_pkg::SIG_SERB_RX]) begin
      serial_b_receive = pin_read[sig_pin[pcx_pkg::SIG_SERB_RX]];
    end
    if (sig_hit[pcx_pkg::SIG_IRQA]) begin
      ext_irq_input_a = pin_read[sig_pin[pcx_pkg::SIG_IRQA]];
    end
    if (sig_hit[pcx_pkg::SIG_IRQB]) begin
      ext_irq_input_b = pin_read[sig_pin[pcx_pkg::SIG_IRQB]];
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        port_data[i]            <= pcx_pkg::RST_DATA;
        port_output_mode_reg[i] <= pcx_pkg::RST_MODE;
      end
      port1_input_mode_reg <= pcx_pkg::RST_INMODE;
      crossbar_cfg_a       <= pcx_pkg::RST_XCFG;
      crossbar_cfg_b       <= pcx_pkg::RST_XCFG;
      crossbar_cfg_c       <= pcx_pkg::RST_XCFG;
      irq_enable           <= pcx_pkg::RST_IRQ_EN;
    end else if (dp_write) begin
      if (in_range(dp_addr, pcx_pkg::OFS_DATA0, pcx_pkg::OFS_DATA3) ||
          in_range(dp_addr, pcx_pkg::OFS_LATCH0, pcx_pkg::OFS_LATCH3)) begin
        port_data[port_idx(dp_addr)] <= hwdata[7:0];
      end
      if (in_range(dp_addr, pcx_pkg::OFS_MODE0, pcx_pkg::OFS_MODE3)) begin
        port_output_mode_reg[port_idx(dp_addr)] <= hwdata[7:0];
      end
      case (dp_addr)
        pcx_pkg::OFS_INMODE1: port1_input_mode_reg <= hwdata[7:0];
        pcx_pkg::OFS_XCFG_A:  crossbar_cfg_a       <= hwdata[7:0];
        pcx_pkg::OFS_XCFG_B:  crossbar_cfg_b       <= hwdata[7:0];
        pcx_pkg::OFS_XCFG_C:  crossbar_cfg_c       <= hwdata[7:0];
        pcx_pkg::OFS_IRQ_EN:  irq_enable           <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Edge detection on synced pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_prev <= 2'h0;
    end else begin
      edge_prev <= {pin_sync[pcx_pkg::PIN_EDGE_B],
                    pin_sync[pcx_pkg::PIN_EDGE_A]};
    end
  end

  always_comb begin
    logic [1:0] now;
    logic [1:0] pol;
    now = {pin_sync[pcx_pkg::PIN_EDGE_B], pin_sync[pcx_pkg::PIN_EDGE_A]};
    pol = {port3_irq_flag_reg[pcx_pkg::IF_POL_B],
           port3_irq_flag_reg[pcx_pkg::IF_POL_A]};
    for (int i = 0; i < 2; i++) begin
      edge_seen[i] = pol[i] ? (now[i] & ~edge_prev[i])
                            : (~now[i] & edge_prev[i]);
    end
  end

  assign edge_wr = dp_write && (dp_addr == pcx_pkg::OFS_PORT3_FLAG);

  // Flag register: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port3_irq_flag_reg <= pcx_pkg::RST_PORT3_FLAG;
    end else begin
      if (edge_wr) begin
        port3_irq_flag_reg[7:2] <= hwdata[7:2];
        port3_irq_flag_reg[pcx_pkg::IF_FLAG_A] <=
          (port3_irq_flag_reg[pcx_pkg::IF_FLAG_A] & hwdata[0])
          | edge_seen[0];
        port3_irq_flag_reg[pcx_pkg::IF_FLAG_B] <=
          (port3_irq_flag_reg[pcx_pkg::IF_FLAG_B] & hwdata[1])
          | edge_seen[1];
      end else begin
        port3_irq_flag_reg[pcx_pkg::IF_FLAG_A] <=
          port3_irq_flag_reg[pcx_pkg::IF_FLAG_A] | edge_seen[0];
        port3_irq_flag_reg[pcx_pkg::IF_FLAG_B] <=
          port3_irq_flag_reg[pcx_pkg::IF_FLAG_B] | edge_seen[1];
      end
    end
  end

  assign edge_irq_a_req = port3_irq_flag_reg[pcx_pkg::IF_FLAG_A]
                          & irq_enable[0];
  assign edge_irq_b_req = port3_irq_flag_reg[pcx_pkg::IF_FLAG_B]
                          & irq_enable[1];

  // Read mux in address phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (in_range(haddr, pcx_pkg::OFS_DATA0, pcx_pkg::OFS_DATA3)) begin
      next_rdata[7:0] = pin_read[8 * port_idx(haddr) +: 8];
    end
    if (in_range(haddr, pcx_pkg::OFS_LATCH0, pcx_pkg::OFS_LATCH3)) begin
      next_rdata[7:0] = port_data[port_idx(haddr)];
    end
    if (in_range(haddr, pcx_pkg::OFS_MODE0, pcx_pkg::OFS_MODE3)) begin
      next_rdata[7:0] = port_output_mode_reg[port_idx(haddr)];
    end
    case (haddr)
      pcx_pkg::OFS_INMODE1: next_rdata[7:0] = port1_input_mode_reg;
      pcx_pkg::OFS_XCFG_A:  next_rdata[7:0] = crossbar_cfg_a;
      pcx_pkg::OFS_XCFG_B:  next_rdata[7:0] = crossbar_cfg_b;
      pcx_pkg::OFS_XCFG_C:  next_rdata[7:0] = crossbar_cfg_c;
      pcx_pkg::OFS_PORT3_FLAG: next_rdata[7:0] = port3_irq_flag_reg;
      pcx_pkg::OFS_IRQ_EN:  next_rdata[1:0] = irq_enable;
      default: ;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule : pcx_port_crossbar

`default_nettype wire

// ---- logic/pcx_pkg.sv ----
// Package for the lower-port crossbar and pin configuration block.
// Assumes a 32-bit AHB-Lite register bus and four 8-bit ports.
package pcx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DATA0    = 8'h00;
  localparam logic [7:0] OFS_DATA3    = 8'h0C;
  localparam logic [7:0] OFS_MODE0    = 8'h10;
  localparam logic [7:0] OFS_MODE3    = 8'h1C;
  localparam logic [7:0] OFS_INMODE1  = 8'h20;
  localparam logic [7:0] OFS_XCFG_A   = 8'h24;
  localparam logic [7:0] OFS_XCFG_B   = 8'h28;
  localparam logic [7:0] OFS_XCFG_C   = 8'h2C;
  localparam logic [7:0] OFS_PORT3_FLAG = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] OFS_LATCH0   = 8'h40;
  localparam logic [7:0] OFS_LATCH3   = 8'h4C;

  // Reset values
  localparam logic [7:0] RST_DATA     = 8'hFF;
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_INMODE   = 8'hFF;
  localparam logic [7:0] RST_XCFG     = 8'h00;
  localparam logic [7:0] RST_PORT3_FLAG = 8'h00;
  localparam logic [1:0] RST_IRQ_EN   = 2'h0;

  // Field positions
  localparam int XA_SMBUS_EN   = 0;
  localparam int XA_SERA_EN    = 2;
  localparam int XB_IRQA_EN    = 2;
  localparam int XB_IRQB_EN    = 4;
  localparam int XC_MEMIF_LOW  = 1;
  localparam int XC_SERB_EN    = 2;
  localparam int XC_XBAR_EN    = 6;
  localparam int XC_PU_DIS     = 7;
  localparam int IF_FLAG_A     = 0;
  localparam int IF_FLAG_B     = 1;
  localparam int IF_POL_A      = 2;
  localparam int IF_POL_B      = 3;

  // Pin indices, port*8+bit
  localparam int PIN_MEMIF_ALE = 5;
  localparam int PIN_MEMIF_RD  = 6;
  localparam int PIN_MEMIF_WR  = 7;
  localparam int PIN_P1_BASE   = 8;
  localparam int PIN_EDGE_A    = 30;
  localparam int PIN_EDGE_B    = 31;

  // Crossbar signals in priority order
  localparam int NSIG       = 8;
  localparam int SIG_SERA_TX = 0;
  localparam int SIG_SERA_RX = 1;
  localparam int SIG_SDA     = 2;
  localparam int SIG_SCL     = 3;
  localparam int SIG_SERB_TX = 4;
  localparam int SIG_SERB_RX = 5;
  localparam int SIG_IRQA    = 6;
  localparam int SIG_IRQB    = 7;

  // Signal kinds: 1 = input to the peripheral
  localparam logic [NSIG-1:0] SIG_IS_INPUT = 8'hE2;
  // Signals that are always open-drain
  localparam logic [NSIG-1:0] SIG_IS_OD    = 8'h0C;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : pcx_pkg

// ---- verif/pcx_pin_model.sv ----
// Model of the circuitry on the lower port pins.
// Assumes pin_oe high means the device drives the pin.
`timescale 1ns/1ps
`default_nettype none
module pcx_pin_model (
  input  wire logic        hclk,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pullup_en,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_drv,
  output logic      [31:0] pin_level
);
  logic [31:0] float_q;
  initial float_q = 32'h55555555;
  // Undriven pins without pull-up wander
  always @(posedge hclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_drv[i];
      else if (pin_pullup_en[i]) pin_level[i] = 1'b1;
      else pin_level[i] = float_q[i];
    end
  end
endmodule : pcx_pin_model
`default_nettype wire

// ---- verif/pcx_port_crossbar_sva.sv ----
// Port-level assertions for the crossbar block.
// Assumes one hclk domain; memif_active only with memif on low ports.
`timescale 1ns/1ps
`default_nettype none
module pcx_port_crossbar_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup_en,
  input wire logic        sda_in,
  input wire logic        memif_active,
  input wire logic        memif_read,
  input wire logic [31:0] memif_data_mask,
  input wire logic [31:0] memif_pin_mask,
  input wire logic [31:0] memif_out,
  input wire logic        edge_irq_a_req,
  input wire logic        edge_irq_b_req
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic wr;
  logic rd;
  assign wr = hsel && hready && htrans[1] && hwrite;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  a_pullup_drive_low: assert property (
    (pin_pullup_en & pin_oe & ~pin_out) == 32'h0) else $error("pull-up on");
  a_reset_pins_idle: assert property (
    $rose(hresetn) |-> pin_oe == 32'h0 && &pin_pullup_en)
    else $error("pins not idle after reset");
  a_edge_a_cause: assert property (
    $rose(edge_irq_a_req) |-> $past(wr, 2) ||
      ($past(pin_in[30], 2) != $past(pin_in[30], 5)))
    else $error("request a without cause");
  a_edge_b_cause: assert property (
    $rose(edge_irq_b_req) |-> $past(wr, 2) ||
      ($past(pin_in[31], 2) != $past(pin_in[31], 5)))
    else $error("request b without cause");
  a_flag_held: assert property (
    $fell(edge_irq_a_req) || $fell(edge_irq_b_req) |-> $past(wr, 2))
    else $error("request dropped without write");
  a_sda_synced: assert property (
    $fell(sda_in) |-> $past(pin_in, 2) != 32'hFFFFFFFF)
    else $error("data line low without low pin");
  a_memif_drive: assert property (
    memif_active && !memif_read |->
      ((pin_out ^ memif_out) & memif_pin_mask & pin_oe) == 32'h0)
    else $error("memif value not on pins");
  a_memif_read_off: assert property (
    memif_active && memif_read |->
      (pin_oe & memif_data_mask & memif_pin_mask) == 32'h0)
    else $error("data bus driven during read");
  a_rdata_holds: assert property (
    !$past(rd) |-> $stable(hrdata)) else $error("read data moved");
  c_edge_a: cover property ($rose(edge_irq_a_req));
  c_memif_rd: cover property (memif_active && memif_read);
  c_sda_low: cover property ($fell(sda_in));
endmodule : pcx_port_crossbar_sva
bind pcx_port_crossbar pcx_port_crossbar_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
  .sda_in(sda_in), .memif_active(memif_active), .memif_read(memif_read),
  .memif_data_mask(memif_data_mask), .memif_pin_mask(memif_pin_mask),
  .memif_out(memif_out), .edge_irq_a_req(edge_irq_a_req),
  .edge_irq_b_req(edge_irq_b_req));
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the lower-port crossbar block.
// Assumes a zero-wait AHB-Lite slave and the pin model on its pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, pin_in, pin_out, pin_oe, pin_pu, rd;
  logic [31:0] ext_en, ext_drv, mm_pin, mm_data, mm_out;
  logic        sa_tx, sa_rx, sda_dr, sda_in, scl_dr, scl_in, sb_tx, sb_rx;
  logic        irq_a, irq_b, mm_mux, mm_act, mm_rd, req_a, req_b;
  int          errors, compares;

  pcx_port_crossbar DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .serial_a_transmit(sa_tx),
    .serial_a_receive(sa_rx), .sda_drive(sda_dr), .sda_in(sda_in),
    .scl_drive(scl_dr), .scl_in(scl_in), .serial_b_transmit(sb_tx),
    .serial_b_receive(sb_rx), .ext_irq_input_a(irq_a),
    .ext_irq_input_b(irq_b), .memif_muxed(mm_mux),
    .memif_active(mm_act), .memif_read(mm_rd), .memif_pin_mask(mm_pin),
    .memif_data_mask(mm_data), .memif_out(mm_out),
    .edge_irq_a_req(req_a), .edge_irq_b_req(req_b));
  pcx_pin_model u_pins (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .ext_en(ext_en), .ext_drv(ext_drv),
    .pin_level(pin_in));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= pcx_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  task automatic t_reset;
    #1;
    check(pin_oe, 32'h0);
    check(pin_pu, 32'hFFFFFFFF);
    check({31'h0, hresp}, 32'h0);
    rdc(pcx_pkg::OFS_MODE0, 32'h0);
    rdc(pcx_pkg::OFS_INMODE1, 32'hFF);
    rdc(pcx_pkg::OFS_LATCH0, 32'hFF);
    rdc(8'h3C, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_gpio;
    wr(pcx_pkg::OFS_MODE0, 32'h01);
    wr(pcx_pkg::OFS_LATCH0, 32'hEF);
    check(pin_oe, 32'h0);
    wr(pcx_pkg::OFS_XCFG_C, 32'h40);
    check(pin_oe & 32'hFF, 32'h11);
    check(pin_out & 32'hFF, 32'hEF);
    check(pin_pu & 32'hFF, 32'hEF);
    tick(3);
    rdc(pcx_pkg::OFS_DATA0, 32'hEF);
    wr(pcx_pkg::OFS_XCFG_C, 32'hC0);
    check(pin_pu, 32'h0);
    wr(pcx_pkg::OFS_XCFG_C, 32'h40);
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_analog;
    wr(pcx_pkg::OFS_INMODE1, 32'hE3);
    wr(pcx_pkg::OFS_MODE0 + 8'h04, 32'hFF);
    check((pin_pu >> 8) & 32'hFF, 32'hE3);
    check((pin_oe >> 8) & 32'hFF, 32'hFF);
    wr(pcx_pkg::OFS_MODE0 + 8'h04, 32'h00);
    tick(3);
    rdc(pcx_pkg::OFS_DATA0 + 8'h04, 32'hE3);
    $display("test analog done");
  endtask : t_analog

  task automatic t_xbar;
    @(posedge hclk);
    mm_mux <= 1'b1;
    sa_tx  <= 1'b0;
    ext_en <= 32'h0000230E;
    wr(pcx_pkg::OFS_MODE0, 32'hFF);
    wr(pcx_pkg::OFS_XCFG_A, 32'h05);
    wr(pcx_pkg::OFS_XCFG_B, 32'h14);
    wr(pcx_pkg::OFS_XCFG_C, 32'h46);
    tick(3);
    check({26'h0, sa_rx, sda_in, scl_in, sb_rx, irq_a, irq_b}, 32'h0);
    check(pin_oe & 32'hFF, 32'hF1);
    check(pin_out & pin_oe & 32'hFF, 32'hF0);
    @(posedge hclk);
    sda_dr <= 1'b0;
    tick(1);
    check(pin_oe & ~pin_out & 32'h0C, 32'h04);
    @(posedge hclk);
    sda_dr <= 1'b1;
    mm_mux <= 1'b0;
    ext_en <= 32'h00000020;
    tick(3);
    check({29'h0, sb_rx, irq_a, irq_b}, 32'h3);
    wr(pcx_pkg::OFS_XCFG_A, 32'h00);
    wr(pcx_pkg::OFS_XCFG_B, 32'h00);
    $display("test crossbar done");
  endtask : t_xbar

  task automatic t_memif;
    wr(pcx_pkg::OFS_MODE0 + 8'h08, 32'hFF);
    @(posedge hclk);
    mm_pin  <= 32'h00FF0000;
    mm_data <= 32'h00FF0000;
    mm_out  <= 32'h00A50000;
    mm_act  <= 1'b1;
    tick(1);
    check(pin_out & pin_oe & mm_pin, 32'h00A50000);
    check(pin_oe & mm_pin, 32'h00FF0000);
    @(posedge hclk);
    mm_rd <= 1'b1;
    tick(1);
    check(pin_oe & mm_data, 32'h0);
    @(posedge hclk);
    mm_act <= 1'b0;
    mm_rd  <= 1'b0;
    tick(1);
    check(pin_out & mm_pin, 32'h00FF0000);
    $display("test memif done");
  endtask : t_memif

  task automatic t_edge;
    wr(pcx_pkg::OFS_PORT3_FLAG, 32'h08);
    wr(pcx_pkg::OFS_IRQ_EN, 32'h03);
    check({30'h0, req_b, req_a}, 32'h0);
    @(posedge hclk);
    ext_en <= 32'hC0000000;
    tick(4);
    check({30'h0, req_b, req_a}, 32'h1);
    @(posedge hclk);
    ext_en <= 32'h0;
    tick(4);
    check({30'h0, req_b, req_a}, 32'h3);
    rdc(pcx_pkg::OFS_PORT3_FLAG, 32'h0B);
    wr(pcx_pkg::OFS_PORT3_FLAG, 32'h09);
    check({30'h0, req_b, req_a}, 32'h1);
    wr(pcx_pkg::OFS_IRQ_EN, 32'h00);
    check({30'h0, req_b, req_a}, 32'h0);
    rdc(pcx_pkg::OFS_PORT3_FLAG, 32'h09);
    $display("test edge done");
  endtask : t_edge

  initial begin
    {hresetn, hsel, hwrite, mm_mux, mm_act, mm_rd} = 6'h0;
    {sa_tx, sda_dr, scl_dr, sb_tx} = 4'hF;
    haddr = 8'h0;
    htrans = 2'h0;
    {hwdata, ext_en, ext_drv, mm_pin, mm_data, mm_out} = '0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_analog();
    t_xbar();
    t_memif();
    t_edge();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
